// [logic/vtsup_pkg.sv]
// Purpose: shared constants and types for the transformer supervision state logic
// Assumes: 100 MHz ref_clk, 5 ms program cycle
// Notes:   register offsets are word indices on the Avalon-MM slave
`default_nettype none
package vtsup_pkg;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned TICK_MS       = 5;
   localparam int unsigned TICK_NS       = TICK_MS * 1000000;
   localparam int unsigned TICK_CYC      = TICK_NS / CLK_PERIOD_NS;
   localparam int unsigned HIST_MS       = 40;
   localparam int unsigned HIST_DEPTH    = HIST_MS / TICK_MS;
   localparam int unsigned MAX_OP_S      = 1800;
   localparam int unsigned MAX_OP_TICKS  = MAX_OP_S * 1000 / TICK_MS;
   localparam int unsigned ANG_FULL      = 36000;   // 0.01 deg units
   localparam int unsigned REC_DEPTH     = 12;
   localparam int unsigned NUM_COND      = 6;
   // ------------------------------------------------------------
   // register word indices
   // ------------------------------------------------------------
   localparam logic [4:0] REG_CTRL    = 5'h00;
   localparam logic [4:0] REG_LOW_TH  = 5'h01;
   localparam logic [4:0] REG_HIGH_TH = 5'h02;
   localparam logic [4:0] REG_ANG_LIM = 5'h03;
   localparam logic [4:0] REG_DELAY   = 5'h04;
   localparam logic [4:0] REG_EVT_EN  = 5'h05;
   localparam logic [4:0] REG_STATUS  = 5'h06;
   localparam logic [4:0] REG_EXP_T   = 5'h07;
   localparam logic [4:0] REG_REMAIN  = 5'h08;
   localparam logic [4:0] REG_CNT0    = 5'h09;
   localparam logic [4:0] REG_REC_SEL = 5'h0D;
   localparam logic [4:0] REG_REC_PTR = 5'h0E;
   localparam logic [4:0] REG_REC0    = 5'h0F;
   localparam int unsigned REC_WORDS  = 5;
   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int unsigned CTRL_CLR_BIT   = 0;
   localparam int unsigned CTRL_BUSF_BIT  = 1;
   localparam int unsigned CTRL_LINEF_BIT = 2;
   localparam int unsigned EVT_OFF_POS    = 8;
   localparam logic [15:0] LOW_TH_RST     = 16'h0032;  // 0.05 Un, 0.001 Un units
   localparam logic [15:0] HIGH_TH_RST    = 16'h0320;  // 0.80 Un
   localparam logic [15:0] ANG_LIM_RST    = 16'h01F4;  // 5.00 deg
   localparam logic [18:0] DELAY_RST      = 19'h00014; // 100 ms
   localparam logic [5:0]  EVT_EN_RST     = 6'h3F;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      COND_NORMAL, COND_STARTED, COND_LINE_FAIL, COND_BUS_FAIL, COND_BLOCKED
   } vtsup_cond_e;
   typedef enum logic [2:0] {
      BUS_DEAD, BUS_LIVE_OK, BUS_LIVE_REV, BUS_LIVE_UNDEF, BUS_LIVE_PROBLEM
   } vtsup_bus_e;
   typedef enum logic [1:0] {VOLT_NONE, VOLT_GOOD, VOLT_LOW} vtsup_volt_e;
   // condition index: start, trip, block, line vt fail, bus fuse, line fuse
   // event code = 2*index for ON, 2*index+1 for OFF
   typedef struct packed {
      logic [3:0]  code;
      logic [31:0] stamp;
   } vtsup_evt_s;
   typedef struct packed {
      logic [31:0]       stamp;
      logic [3:0]        code;
      logic [3:0][1:0]   vstat;
      logic [3:0][15:0]  adiff;
      logic [19:0]       remain;
      logic [2:0]        sys;
      logic [2:0]        group;
   } vtsup_rec_s;
endpackage : vtsup_pkg
`default_nettype wire

// [logic/vtsup_top.sv]
// Purpose: transformer supervision status, blocking, delay, events and records
// Assumes: measurement inputs and blocking input synchronous to ref_clk
// Notes:   registers on Avalon-MM slave, one word per register
//
// What this block does
// - sample blocking once per program cycle
// - pick-up unblocked asserts start, starts timing
// - pick-up while blocked asserts blocked only
// - blocking after start drops start, releases
// - definite delay only, operate after fixed time
// - readable five-valued condition status
// - readable five-valued bus voltage state
// - readable expected operating time, 5 ms steps
// - signed remaining time decreasing each cycle
// - per event ON, OFF selection to buffer
// - events stamped at detection time
// - clearable counters start, trip, line, blocked
// - twelve ON/OFF event codes, six conditions
// - ON events write twelve-entry record ring
// - record holds stamp, event, channel statuses
// - record holds angles, remaining, status, group
// - pick-up: one low or two high
// - suppress pick-up on small 40 ms angle shift
// - bus and line fuse supervision enables
//
// Design decisions made here: the address map and register access over Avalon-MM.
`default_nettype none
module vtsup_top #(
   parameter int unsigned TICK_CYCLES = vtsup_pkg::TICK_CYC,
   parameter int unsigned MAG_W       = 16
) (
   // clock and reset
   input  wire logic                  ref_clk,
   input  wire logic                  resetn,
   // avalon-mm slave
   input  wire logic [4:0]            avs_address,
   input  wire logic                  avs_read,
   input  wire logic                  avs_write,
   input  wire logic [31:0]           avs_writedata,
   input  wire logic [3:0]            avs_byteenable,
   output logic      [31:0]           avs_readdata,
   output logic                       avs_waitrequest,
   // measurement and system inputs
   input  wire logic [3:0][MAG_W-1:0] volt_mag,
   input  wire logic [3:0][15:0]      volt_ang,
   input  wire logic                  seq_reversed,
   input  wire logic                  seq_undefined,
   input  wire logic                  block_in,
   input  wire logic                  bus_fuse_trip,
   input  wire logic                  line_fuse_trip,
   input  wire logic [31:0]           time_ms,
   input  wire logic [2:0]            setting_group,
   // function outputs
   output logic                       start_out,
   output logic                       trip_out,
   output logic                       blocked_out,
   output logic                       line_transformer_failure,
   output logic                       bus_transformer_failure,
   // event stream
   output logic                       evt_valid,
   output vtsup_pkg::vtsup_evt_s      evt_out
);
   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   function automatic logic [15:0] ang_diff(input logic [15:0] a, input logic [15:0] b);
      ang_diff = (a >= b) ? a - b : b - a;
   endfunction : ang_diff
   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be);
      for (int i = 0; i < 4; i++) begin
         be_merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction : be_merge

   // ------------------------------------------------------------
   // program cycle tick
   // ------------------------------------------------------------
   logic [19:0] tick_cnt_r;
   logic        tick_r;
   logic        tick_d_r;
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         tick_cnt_r <= 20'h00000;
         tick_r     <= 1'b0;
      end else begin
         tick_r     <= (tick_cnt_r == 20'(TICK_CYCLES - 1));
         tick_cnt_r <= (tick_cnt_r == 20'(TICK_CYCLES - 1)) ? 20'h00000 : tick_cnt_r + 20'h00001;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) tick_d_r <= 1'b0;
      else         tick_d_r <= tick_r;
   end

   // ------------------------------------------------------------
   // settings registers
   // ------------------------------------------------------------
   logic [31:0] low_th_r, high_th_r, ang_lim_r, delay_r, evt_en_r, rec_sel_r;
   logic        busf_en_r, linef_en_r, cnt_clr_r;
   logic        wait_r;
   logic        wr_go;
   assign wr_go = avs_write && !wait_r;
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         low_th_r   <= 32'(vtsup_pkg::LOW_TH_RST);
         high_th_r  <= 32'(vtsup_pkg::HIGH_TH_RST);
         ang_lim_r  <= 32'(vtsup_pkg::ANG_LIM_RST);
         delay_r    <= 32'(vtsup_pkg::DELAY_RST);
         evt_en_r   <= {18'h00000, vtsup_pkg::EVT_EN_RST, 2'h0, vtsup_pkg::EVT_EN_RST};
         rec_sel_r  <= 32'h00000000;
         busf_en_r  <= 1'b1;
         linef_en_r <= 1'b1;
         cnt_clr_r  <= 1'b0;
      end else begin
         cnt_clr_r <= 1'b0;
         if (wr_go) begin
            unique case (avs_address)
               vtsup_pkg::REG_CTRL: begin
                  cnt_clr_r  <= avs_byteenable[0] && avs_writedata[vtsup_pkg::CTRL_CLR_BIT];
                  if (avs_byteenable[0]) begin
                     busf_en_r  <= avs_writedata[vtsup_pkg::CTRL_BUSF_BIT];
                     linef_en_r <= avs_writedata[vtsup_pkg::CTRL_LINEF_BIT];
                  end
               end
               vtsup_pkg::REG_LOW_TH:  low_th_r  <= be_merge(low_th_r, avs_writedata, avs_byteenable);
               vtsup_pkg::REG_HIGH_TH: high_th_r <= be_merge(high_th_r, avs_writedata, avs_byteenable);
               vtsup_pkg::REG_ANG_LIM: ang_lim_r <= be_merge(ang_lim_r, avs_writedata, avs_byteenable);
               vtsup_pkg::REG_DELAY: begin
                  delay_r <= be_merge(delay_r, avs_writedata, avs_byteenable);
               end
               vtsup_pkg::REG_EVT_EN:  evt_en_r  <= be_merge(evt_en_r, avs_writedata, avs_byteenable);
               vtsup_pkg::REG_REC_SEL: rec_sel_r <= be_merge(rec_sel_r, avs_writedata, avs_byteenable);
               default: ;
            endcase
         end
      end
   end
   logic [18:0] delay_t;
   assign delay_t = (delay_r[18:0] > 19'(vtsup_pkg::MAX_OP_TICKS)) ?
                    19'(vtsup_pkg::MAX_OP_TICKS) : delay_r[18:0];

   // ------------------------------------------------------------
   // pick-up and angle history
   // ------------------------------------------------------------
   logic [3:0][15:0] ang_hist_r [vtsup_pkg::HIST_DEPTH];
   logic [3:0][15:0] adiff;
   logic [3:0][1:0]  vstat;
   logic [1:0]       n_high;
   logic             any_low, ang_quiet, pick;
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         for (int i = 0; i < vtsup_pkg::HIST_DEPTH; i++) ang_hist_r[i] <= '0;
      end else if (tick_r) begin
         ang_hist_r[0] <= volt_ang;
         for (int i = 1; i < vtsup_pkg::HIST_DEPTH; i++) ang_hist_r[i] <= ang_hist_r[i-1];
      end
   end
   always_comb begin
      any_low   = 1'b0;
      n_high    = 2'h0;
      ang_quiet = 1'b1;
      for (int c = 0; c < 4; c++) begin
         adiff[c] = ang_diff(volt_ang[c], ang_hist_r[vtsup_pkg::HIST_DEPTH-1][c]);
         vstat[c] = (volt_mag[c] < low_th_r[MAG_W-1:0])  ? 2'(vtsup_pkg::VOLT_NONE) :
                    (volt_mag[c] < high_th_r[MAG_W-1:0]) ? 2'(vtsup_pkg::VOLT_LOW)  :
                                                           2'(vtsup_pkg::VOLT_GOOD);
      end
      for (int c = 0; c < 3; c++) begin
         any_low   = any_low | (volt_mag[c] < low_th_r[MAG_W-1:0]);
         n_high    = n_high + 2'(volt_mag[c] > high_th_r[MAG_W-1:0]);
         ang_quiet = ang_quiet & (adiff[c] < ang_lim_r[15:0]);
      end
      pick = (any_low || n_high >= 2'h2) && !ang_quiet;
   end

   // ------------------------------------------------------------
   // blocking, start and definite delay
   // ------------------------------------------------------------
   logic        blk_s_r, start_r, blocked_r, trip_r, pick_r;
   logic        blk_cyc;
   logic [18:0] elapsed_r;
   assign blk_cyc = tick_r ? block_in : blk_s_r;
   always_ff @(posedge ref_clk) begin
      if (!resetn) blk_s_r <= 1'b0;
      else if (tick_r) blk_s_r <= block_in;
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         start_r   <= 1'b0;
         blocked_r <= 1'b0;
         pick_r    <= 1'b0;
      end else if (tick_r) begin
         pick_r    <= pick;
         start_r   <= pick && !blk_cyc;
         blocked_r <= pick && blk_cyc;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         elapsed_r <= 19'h00000;
         trip_r    <= 1'b0;
      end else if (tick_r) begin
         if (pick && !blk_cyc) begin
            if (start_r && elapsed_r < delay_t) elapsed_r <= elapsed_r + 19'h00001;
            trip_r <= start_r && (elapsed_r + 19'h00001 >= delay_t);
         end else begin
            elapsed_r <= 19'h00000;
            trip_r    <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // condition and bus state
   // ------------------------------------------------------------
   vtsup_pkg::vtsup_cond_e cond_r;
   vtsup_pkg::vtsup_bus_e  bus_r;
   logic                   busf_r, linef_r, line_vt_r;
   logic signed [19:0]     remain_r;
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         busf_r    <= 1'b0;
         linef_r   <= 1'b0;
         line_vt_r <= 1'b0;
         cond_r    <= vtsup_pkg::COND_NORMAL;
         bus_r     <= vtsup_pkg::BUS_DEAD;
         remain_r  <= 20'sh00000;
      end else begin
         busf_r    <= busf_en_r && bus_fuse_trip;
         linef_r   <= linef_en_r && line_fuse_trip;
         line_vt_r <= linef_r && pick_r;
         remain_r  <= signed'({1'b0, delay_t}) - signed'({1'b0, elapsed_r});
         if (blocked_r)                cond_r <= vtsup_pkg::COND_BLOCKED;
         else if (trip_r || busf_r)    cond_r <= vtsup_pkg::COND_BUS_FAIL;
         else if (line_vt_r)           cond_r <= vtsup_pkg::COND_LINE_FAIL;
         else if (start_r)             cond_r <= vtsup_pkg::COND_STARTED;
         else                          cond_r <= vtsup_pkg::COND_NORMAL;
         if (vstat[2:0] == {3{2'(vtsup_pkg::VOLT_NONE)}}) bus_r <= vtsup_pkg::BUS_DEAD;
         else if (pick_r)        bus_r <= vtsup_pkg::BUS_LIVE_PROBLEM;
         else if (seq_undefined) bus_r <= vtsup_pkg::BUS_LIVE_UNDEF;
         else if (seq_reversed)  bus_r <= vtsup_pkg::BUS_LIVE_REV;
         else                    bus_r <= vtsup_pkg::BUS_LIVE_OK;
      end
   end

   // ------------------------------------------------------------
   // edge detection, counters, event emission
   // ------------------------------------------------------------
   logic [5:0]       cur6, prev6_r;
   logic [11:0]      pend_r, pick_one;
   logic [31:0]      stamp_r;
   logic [3:0][15:0] cnt_r;
   logic [3:0]       code;
   assign cur6 = {linef_r, busf_r, line_vt_r, blocked_r, trip_r, start_r};
   always_comb begin
      code     = 4'h0;
      pick_one = 12'h000;
      for (int i = 11; i >= 0; i--) begin
         if (pend_r[i]) begin
            code     = 4'(i);
            pick_one = 12'h001 << i;
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         prev6_r <= 6'h00;
         pend_r  <= 12'h000;
         stamp_r <= 32'h00000000;
      end else begin
         pend_r <= pend_r & ~pick_one;
         if (tick_d_r) begin
            prev6_r <= cur6;
            if (cur6 != prev6_r) stamp_r <= time_ms;
            for (int i = 0; i < vtsup_pkg::NUM_COND; i++) begin
               if (cur6[i] && !prev6_r[i]) pend_r[2*i]   <= 1'b1;
               if (!cur6[i] && prev6_r[i]) pend_r[2*i+1] <= 1'b1;
            end
         end
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cnt_r <= '0;
      end else if (cnt_clr_r) begin
         cnt_r <= '0;
      end else if (tick_d_r) begin
         if (cur6[0] && !prev6_r[0]) cnt_r[0] <= cnt_r[0] + 16'h0001;
         if (cur6[1] && !prev6_r[1]) cnt_r[1] <= cnt_r[1] + 16'h0001;
         if (cur6[3] && !prev6_r[3]) cnt_r[2] <= cnt_r[2] + 16'h0001;
         if (cur6[2] && !prev6_r[2]) cnt_r[3] <= cnt_r[3] + 16'h0001;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         evt_valid <= 1'b0;
         evt_out   <= '0;
      end else begin
         evt_valid     <= |pend_r && (code[0] ? evt_en_r[vtsup_pkg::EVT_OFF_POS + 32'(code[3:1])]
                                              : evt_en_r[code[3:1]]);
         evt_out.code  <= code;
         evt_out.stamp <= stamp_r;
      end
   end

   // ------------------------------------------------------------
   // record ring
   // ------------------------------------------------------------
   vtsup_pkg::vtsup_rec_s rec_mem [vtsup_pkg::REC_DEPTH];
   logic [3:0]            wr_ptr_r, rec_cnt_r;
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         wr_ptr_r  <= 4'h0;
         rec_cnt_r <= 4'h0;
      end else if (|pend_r && !code[0]) begin
         rec_mem[wr_ptr_r] <= '{stamp: stamp_r, code: code, vstat: vstat, adiff: adiff,
                                remain: remain_r, sys: bus_r, group: setting_group};
         wr_ptr_r <= (wr_ptr_r == 4'(vtsup_pkg::REC_DEPTH - 1)) ? 4'h0 : wr_ptr_r + 4'h1;
         if (rec_cnt_r != 4'(vtsup_pkg::REC_DEPTH)) rec_cnt_r <= rec_cnt_r + 4'h1;
      end
   end

   // ------------------------------------------------------------
   // bus read and waitrequest
   // ------------------------------------------------------------
   vtsup_pkg::vtsup_rec_s sel_rec;
   logic [31:0]           rd_mux;
   assign sel_rec = rec_mem[(rec_sel_r[3:0] < 4'(vtsup_pkg::REC_DEPTH)) ? rec_sel_r[3:0] : 4'h0];
   always_comb begin
      rd_mux = 32'h00000000;
      unique case (avs_address)
         vtsup_pkg::REG_CTRL:    rd_mux = {29'h0, linef_en_r, busf_en_r, 1'b0};
         vtsup_pkg::REG_LOW_TH:  rd_mux = low_th_r;
         vtsup_pkg::REG_HIGH_TH: rd_mux = high_th_r;
         vtsup_pkg::REG_ANG_LIM: rd_mux = ang_lim_r;
         vtsup_pkg::REG_DELAY:   rd_mux = delay_r;
         vtsup_pkg::REG_EVT_EN:  rd_mux = evt_en_r;
         vtsup_pkg::REG_STATUS:  rd_mux = {24'h0, 1'b0, bus_r, 1'b0, cond_r};
         vtsup_pkg::REG_EXP_T:   rd_mux = {13'h0, delay_t};
         vtsup_pkg::REG_REMAIN:  rd_mux = 32'(remain_r);
         5'h09, 5'h0A, 5'h0B, 5'h0C:
            rd_mux = {16'h0, cnt_r[avs_address[1:0] - vtsup_pkg::REG_CNT0[1:0]]};
         vtsup_pkg::REG_REC_SEL: rd_mux = rec_sel_r;
         vtsup_pkg::REG_REC_PTR: rd_mux = {24'h0, rec_cnt_r, wr_ptr_r};
         5'h0F: rd_mux = sel_rec.stamp;
         5'h10: rd_mux = {14'h0, sel_rec.code, sel_rec.vstat, sel_rec.sys, sel_rec.group};
         5'h11: rd_mux = 32'(signed'(sel_rec.remain));
         5'h12: rd_mux = {sel_rec.adiff[1], sel_rec.adiff[0]};
         5'h13: rd_mux = {sel_rec.adiff[3], sel_rec.adiff[2]};
         default: rd_mux = 32'h00000000;
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         wait_r       <= 1'b1;
         avs_readdata <= 32'h00000000;
      end else begin
         wait_r <= !((avs_read || avs_write) && wait_r);
         if (avs_read && wait_r) avs_readdata <= rd_mux;
      end
   end
   assign avs_waitrequest = wait_r;
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         start_out                <= 1'b0;
         trip_out                 <= 1'b0;
         blocked_out              <= 1'b0;
         line_transformer_failure <= 1'b0;
         bus_transformer_failure  <= 1'b0;
      end else begin
         start_out                <= start_r;
         trip_out                 <= trip_r;
         blocked_out              <= blocked_r;
         line_transformer_failure <= line_vt_r;
         bus_transformer_failure  <= trip_r || busf_r;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   a_blk_sample_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
      !tick_r |=> $stable(blk_s_r)) else $error("blocking sample changed off tick");
   a_start_go: assert property (@(posedge ref_clk) disable iff (!resetn)
      tick_r && pick && !block_in |=> start_r && !blocked_r) else $error("start missing");
   a_blocked_only: assert property (@(posedge ref_clk) disable iff (!resetn)
      tick_r && pick && block_in |=> blocked_r && !start_r && !trip_r && elapsed_r == 19'h0)
      else $error("blocked pick-up still timing");
   a_trip_after_delay: assert property (@(posedge ref_clk) disable iff (!resetn)
      trip_r |-> start_r && elapsed_r >= delay_t) else $error("trip before delay");
   a_remain_value: assert property (@(posedge ref_clk) disable iff (!resetn)
      1'b1 |=> remain_r == signed'({1'b0, $past(delay_t)}) - signed'({1'b0, $past(elapsed_r)}))
      else $error("remaining time wrong");
   a_evt_enable_sel: assert property (@(posedge ref_clk) disable iff (!resetn)
      evt_valid |-> (evt_out.code[0] ? evt_en_r[vtsup_pkg::EVT_OFF_POS + 32'(evt_out.code[3:1])]
                                     : evt_en_r[evt_out.code[3:1]]))
      else $error("masked event emitted");
   a_cnt_start_inc: assert property (@(posedge ref_clk) disable iff (!resetn)
      tick_d_r && cur6[0] && !prev6_r[0] && !cnt_clr_r |=> cnt_r[0] == $past(cnt_r[0]) + 16'h1)
      else $error("start counter not incremented");
   a_ring_ptr_wrap: assert property (@(posedge ref_clk) disable iff (!resetn)
      wr_ptr_r == 4'hB && |pend_r && !code[0] |=> wr_ptr_r == 4'h0)
      else $error("record ring did not wrap");
   a_cond_blocked: assert property (@(posedge ref_clk) disable iff (!resetn)
      blocked_r |=> cond_r == vtsup_pkg::COND_BLOCKED) else $error("condition not blocked");
endmodule : vtsup_top
`default_nettype wire

// [tb/vtsup_far.sv]
// Purpose: far side model, blocking matrix and time base
// Assumes: one ref_clk domain
// Notes:   block held from request, well ahead of delay expiry
`default_nettype none
module vtsup_far (
   // clock and control
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   input  wire logic        blk_req,
   // to block
   output logic [31:0]      time_ms,
   output logic             block_in
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge ref_clk) begin
      time_ms  <= resetn ? time_ms + 32'h1 : 32'h0;
      block_in <= resetn & blk_req;
   end
endmodule : vtsup_far
`default_nettype wire

// [tb/vtsup_top_tb_top.sv]
// Purpose: self-checking bench for the supervision state logic
// Assumes: short tick of 20 cycles
// Notes:   event codes checked in order through a queue
`default_nettype none
module vtsup_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TK = 20;
   logic                  ref_clk = 1'b0, resetn = 1'b0, rd_en = 1'b0, wr_en = 1'b0;
   logic                  blk = 1'b0, pu = 1'b0, wreq, blkin, st, tr, bk, evv;
   logic                  bft = 1'b0, lft = 1'b0, srv = 1'b0, sud = 1'b0, lt, bt;
   logic [4:0]            addr = 5'h00;
   logic [31:0]           wd = 32'h0, rdat, tms, q;
   logic [3:0][15:0]      mag = '0, ang = '0;
   logic [2:0]            grp = 3'h0;
   vtsup_pkg::vtsup_evt_s evt;
   logic [3:0]            exp_q[$];
   int                    fails = 0, num_checks = 0;
   always #5 ref_clk = ~ref_clk;
   vtsup_far far_u (.ref_clk(ref_clk), .resetn(resetn), .blk_req(blk), .time_ms(tms),
      .block_in(blkin));
   vtsup_top #(.TICK_CYCLES(TK)) dut_u (.ref_clk(ref_clk), .resetn(resetn),
      .avs_address(addr), .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wd),
      .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wreq),
      .volt_mag(mag), .volt_ang(ang), .seq_reversed(srv), .seq_undefined(sud),
      .block_in(blkin), .bus_fuse_trip(bft), .line_fuse_trip(lft), .time_ms(tms),
      .setting_group(grp), .start_out(st), .trip_out(tr), .blocked_out(bk),
      .line_transformer_failure(lt), .bus_transformer_failure(bt), .evt_valid(evv),
      .evt_out(evt));
   task automatic chk(input logic [31:0] e, s, input string nm);
      num_checks++;
      if (s !== e) begin
         fails++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, s);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      addr  <= a;
      wd    <= d;
      wr_en <= w;
      rd_en <= !w;
      do begin
         @(posedge ref_clk);
      end while (wreq !== 1'b0);
      q = rdat;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      @(posedge ref_clk);
   endtask : bus
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0);
      chk(e, q, nm);
   endtask : rd
   task automatic test_done;
      chk(0, exp_q.size(), "evt_left");
      if (fails == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : test_done
   always @(posedge ref_clk) begin
      for (int i = 0; i < 4; i++) begin
         ang[i] <= 16'($urandom_range(35999));
         mag[i] <= (i == 0 && pu) ? 16'h0000 : 16'($urandom_range(16'h2FF, 16'h100));
      end
      grp <= 3'($urandom_range(7));
      if (evv === 1'b1) begin
         chk({28'h0, exp_q.size() ? exp_q[0] : 4'hF}, {28'h0, evt.code}, "evt_code");
         chk(32'h1, {31'h0, tms - evt.stamp < 32'h14}, "evt_stamp");
         if (exp_q.size() > 0) void'(exp_q.pop_front());
      end
   end
   initial begin
      void'($urandom(32'hc295));
      repeat (5) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      rd(vtsup_pkg::REG_DELAY, 32'h14, "delay_rst");
      rd(vtsup_pkg::REG_EVT_EN, 32'h3F3F, "evt_en_rst");
      rd(5'h1F, 32'h0, "unmapped");
      bus(1'b1, vtsup_pkg::REG_DELAY, 32'h3);
      rd(vtsup_pkg::REG_EXP_T, 32'h3, "exp_time");
      blk <= 1'b1;
      repeat (2 * TK) @(posedge ref_clk);
      exp_q.push_back(4'h4);
      pu <= 1'b1;
      repeat (5 * TK) @(posedge ref_clk);
      chk({30'h0, bk, tr}, 32'h2, "blocked_no_trip");
      bus(1'b0, vtsup_pkg::REG_STATUS, 32'h0);
      chk({29'h0, q[2:0]}, 32'h4, "cond_blocked");
      exp_q.push_back(4'h0);
      exp_q.push_back(4'h5);
      exp_q.push_back(4'h2);
      blk <= 1'b0;
      repeat (2 * TK) @(posedge ref_clk);
      chk({31'h0, st}, 32'h1, "start");
      repeat (4 * TK) @(posedge ref_clk);
      chk({31'h0, tr}, 32'h1, "trip");
      rd(vtsup_pkg::REG_CNT0, 32'h1, "cnt_start");
      rd(vtsup_pkg::REG_CNT0 + 5'h3, 32'h1, "cnt_blocked");
      exp_q.push_back(4'h1);
      exp_q.push_back(4'h3);
      pu <= 1'b0;
      repeat (3 * TK) @(posedge ref_clk);
      bus(1'b1, vtsup_pkg::REG_CTRL, 32'h7);
      rd(vtsup_pkg::REG_CNT0 + 5'h1, 32'h0, "cnt_clear");
      exp_q.push_back(4'h8);
      bft <= 1'b1;
      srv <= 1'b1;
      repeat (2 * TK) @(posedge ref_clk);
      chk({31'h0, bt}, 32'h1, "bus_fail");
      bus(1'b0, vtsup_pkg::REG_STATUS, 32'h0);
      chk({25'h0, q[6:0]}, 32'h23, "bus_rev_fail");
      bus(1'b1, vtsup_pkg::REG_CTRL, 32'h2);
      lft <= 1'b1;
      repeat (2 * TK) @(posedge ref_clk);
      exp_q.push_back(4'hA);
      bus(1'b1, vtsup_pkg::REG_CTRL, 32'h6);
      sud <= 1'b1;
      repeat (2 * TK) @(posedge ref_clk);
      bus(1'b0, vtsup_pkg::REG_STATUS, 32'h0);
      chk({25'h0, q[6:0]}, 32'h33, "bus_undef");
      exp_q.push_back(4'h0);
      exp_q.push_back(4'h6);
      exp_q.push_back(4'h2);
      pu <= 1'b1;
      repeat (6 * TK) @(posedge ref_clk);
      chk({31'h0, lt}, 32'h1, "line_fail");
      bus(1'b0, vtsup_pkg::REG_STATUS, 32'h0);
      chk({25'h0, q[6:0]}, 32'h43, "bus_problem");
      test_done();
   end
   initial begin
      repeat (5000) @(posedge ref_clk);
      fails++;
      test_done();
   end
endmodule : vtsup_top_tb_top
`default_nettype wire
